// >>> dcbs_asserts.sv
// dcbs_asserts: port-level checks of the boot sequencer
// assumes it is bound to dcbs_boot_sequencer, single clock domain
`timescale 1ns/1ps
module dcbs_asserts
   import dcbs_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
   // clock, reset and inputs
   input wire logic                   mclk_in,
   input wire logic                   srst_in,
   input wire logic [CAUSE_WIDTH-1:0] reset_cause_in,
   input wire logic                   later_revision_in,
   input wire logic                   debug_probe_in,
   input wire logic                   control_idle_in,
   input wire logic                   wake_request_in,
   // outputs under check
   input wire logic                   control_reset_out,
   input wire logic                   analog_reset_out,
   input wire logic                   analog_interface_bus_reset_out,
   input wire logic                   master_to_control_wake_interrupt_out,
   input wire logic                   gpio_pullup_enable_out,
   input wire logic                   hard_fault_out,
   input wire logic                   boot_done_out,
   input wire dcbs_mode_type          boot_mode_out,
   input wire dcbs_sel_type           boot_sel_out
);
   localparam int REL_LO = 2 * INIT_CYCLES;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   sequence held_s;
      control_reset_out throughout ##REL_LO 1;
   endsequence
   sequence freed_s;
      ##[0:2] !control_reset_out;
   endsequence
   AST_REL_ORDER: assert property ($fell(srst_in) |->
      held_s ##0 freed_s) else $error("subsystem release out of order");
   AST_TOGETHER: assert property (control_reset_out == analog_reset_out &&
      analog_reset_out == analog_interface_bus_reset_out)
      else $error("subsystem resets differ");
   AST_CAUSE: assert property (|reset_cause_in |=>
      control_reset_out && !boot_done_out) else $error("reset cause ignored");
   AST_PULLUP: assert property (!gpio_pullup_enable_out)
      else $error("pull-ups enabled");
   AST_CODE_HOLD: assert property (!control_reset_out &&
      $past(!control_reset_out) |-> $stable(boot_sel_out.code))
      else $error("captured code changed");
   AST_FLASH: assert property (boot_done_out &&
      boot_sel_out.code == SEL_FLASH |-> boot_mode_out == BM_FLASH)
      else $error("code 7 not flash");
   AST_FLAGS: assert property (boot_done_out |->
      boot_sel_out.serial_slave == (boot_mode_out == BM_SERIAL_SLAVE) &&
      boot_sel_out.ssp_master == (boot_mode_out == BM_SSP_MASTER) &&
      boot_sel_out.i2c_master == (boot_mode_out == BM_I2C_MASTER))
      else $error("port role flags wrong");
   AST_INIT_REV: assert property (boot_done_out && !later_revision_in |->
      boot_mode_out != BM_SSP_MASTER && boot_mode_out != BM_I2C_MASTER)
      else $error("master load on initial revision");
   AST_WAKE: assert property (master_to_control_wake_interrupt_out ==
      $past(wake_request_in && control_idle_in && boot_done_out))
      else $error("wake interrupt wrong");
   AST_FAULT: assert property (hard_fault_out && !$past(debug_probe_in) |=>
      !hard_fault_out && control_reset_out) else $error("fault not a reset");
endmodule : dcbs_asserts

bind dcbs_boot_sequencer dcbs_asserts #(.INIT_CYCLES(INIT_CYCLES))
   u_dcbs_asserts (.*);

// >>> dcbs_boot_sequencer.sv
// dcbs_boot_sequencer: master-side boot sequencing of a dual-core device
// assumes boot-select pins, reset cause and status inputs synchronous to mclk
//
// Summary of operation
// - any master reset cause restarts the boot sequence
// - master boot starts when internal reset goes inactive
// - control and analog subsystems stay in reset until master releases
// - device init, then master init, then release control and analog bus
// - control boots in parallel, idles until master wake interrupt
// - in the release cycle, sample four boot-select pins as a code
// - codes 0..4: parallel, RAM, serial, CAN, Ethernet; bit4 is msb
// - code 7 flash; code 6 OTP only on test parts, else flash
// - code 9 sync serial master load, code 10 I2C master load
// - codes 5, 8, 11..15 fall back to flash
// - initial revision ignores bit4, codes 8..15 unsupported
// - later revision may remap boot-select pins; initial uses fixed pins
// - flash without valid code: hard fault, re-enter reset until debugger
// - GPIO pull-ups stay disabled after reset
// - in code 2 serial ports act as slaves
`timescale 1ns/1ps
module dcbs_boot_sequencer
   import dcbs_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
   // clock and reset
   input  wire logic                      mclk_in,
   input  wire logic                      srst_in,
   // master reset causes, one pulse or level per source
   input  wire logic [CAUSE_WIDTH-1:0]    reset_cause_in,
   // part strapping
   input  wire logic                      later_revision_in,
   input  wire logic                      test_version_in,
   input  wire logic                      debug_probe_in,
   // boot-select pins: fixed pins and alternates
   input  wire logic                      boot_select_bit1_in,
   input  wire logic                      boot_select_bit2_in,
   input  wire logic                      boot_select_bit3_in,
   input  wire logic                      boot_select_bit4_in,
   input  wire logic                      remap_enable_in,
   input  wire logic [BOOT_SEL_WIDTH-1:0] remap_select_in,
   // control subsystem handshake
   input  wire logic                      control_idle_in,
   input  wire logic                      wake_request_in,
   input  wire logic                      flash_valid_in,
   // subsystem controls
   output logic                           control_reset_out,
   output logic                           analog_reset_out,
   output logic                           analog_interface_bus_reset_out,
   output logic                           master_to_control_wake_interrupt_out,
   output logic                           gpio_pullup_enable_out,
   output logic                           hard_fault_out,
   // boot dispatch status
   output logic                           boot_busy_out,
   output logic                           boot_done_out,
   output dcbs_mode_type                  boot_mode_out,
   output dcbs_sel_type                   boot_sel_out
);

   initial begin
      if (INIT_CYCLES < 1 || INIT_CYCLES > 65535)
         $error("INIT_CYCLES out of range");
   end

   dcbs_state_type   state_q, state_d;
   logic [15:0]      cnt_q, cnt_d;
   logic [3:0]       code_q;
   dcbs_mode_type    mode_q;
   logic             rel_q, wake_q, fault_q, rev_q, test_q;
   logic             in_rst_q;

   // any master reset source, or the internal reset itself, restarts boot
   wire              any_cause  = |reset_cause_in;
   wire              restart    = srst_in | any_cause;
   wire              cnt_done   = (cnt_q == 16'(INIT_CYCLES - 1));

   // boot-select code as seen on pins
   wire [3:0]        fixed_pins = {boot_select_bit4_in, boot_select_bit3_in,
                                   boot_select_bit2_in, boot_select_bit1_in};
   wire [3:0]        raw_code   = (rev_q & remap_enable_in) ?
                                  remap_select_in : fixed_pins;
   wire [3:0]        live_code  = rev_q ? raw_code :
                                  {1'b0, raw_code[TOP_SEL_BIT-1:0]};

   // decode of the held code
   dcbs_mode_type    dec_mode;
   always_comb begin
      case (code_q)
         SEL_PARALLEL:     dec_mode = BM_PARALLEL;
         SEL_RAM:          dec_mode = BM_RAM;
         SEL_SERIAL_SLAVE: dec_mode = BM_SERIAL_SLAVE;
         SEL_CAN:          dec_mode = BM_CAN;
         SEL_ETHERNET:     dec_mode = BM_ETHERNET;
         SEL_OTP:          dec_mode = test_q ? BM_OTP : BM_FLASH;
         SEL_FLASH:        dec_mode = BM_FLASH;
         SEL_SSP_MASTER:   dec_mode = rev_q ? BM_SSP_MASTER
                                            : BM_FLASH;
         SEL_I2C_MASTER:   dec_mode = rev_q ? BM_I2C_MASTER
                                            : BM_FLASH;
         default:          dec_mode = BM_FLASH;
      endcase
   end

   // sequence: device init, master init, release, sample, dispatch
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_RESET: begin
            state_d = ST_DEV_INIT;
            cnt_d   = '0;
         end
         ST_DEV_INIT: begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_done) begin
               state_d = ST_MST_INIT;
               cnt_d   = '0;
            end
         end
         ST_MST_INIT: begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_done) begin
               state_d = ST_RELEASE;
               cnt_d   = '0;
            end
         end
         ST_RELEASE:  state_d = ST_SAMPLE;
         ST_SAMPLE:   state_d = ST_DISPATCH;
         ST_DISPATCH: begin
            if (mode_q == BM_FLASH && !flash_valid_in)
               state_d = ST_FAULT;
            else
               state_d = ST_RUN;
         end
         ST_RUN:      state_d = ST_RUN;
         ST_FAULT: begin
            if (debug_probe_in)
               state_d = ST_FAULT;
            else
               state_d = ST_RESET;
         end
         default:     state_d = ST_RESET;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (restart) begin
         state_q <= ST_RESET;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // straps taken in the first cycle after reset release
   always_ff @(posedge mclk_in) begin
      in_rst_q <= restart;
      if (in_rst_q && !restart) begin
         rev_q  <= later_revision_in;
         test_q <= test_version_in;
      end
   end

   // code captured once per boot, then held
   always_ff @(posedge mclk_in) begin
      if (restart) begin
         code_q <= 4'h0;
         mode_q <= BM_FLASH;
      end else begin
         if (state_q == ST_RELEASE)
            code_q <= live_code;
         if (state_q == ST_SAMPLE)
            mode_q <= dec_mode;
      end
   end

   // subsystem release and control-side wake
   always_ff @(posedge mclk_in) begin
      if (restart || state_q == ST_FAULT) begin
         rel_q   <= 1'b0;
         wake_q  <= 1'b0;
         fault_q <= (state_q == ST_FAULT) & ~restart;
      end else begin
         fault_q <= 1'b0;
         if (state_q == ST_RELEASE)
            rel_q <= 1'b1;
         wake_q <= (state_q == ST_RUN) & control_idle_in
                   & wake_request_in;
      end
   end

   assign control_reset_out              = ~rel_q;
   assign analog_reset_out               = ~rel_q;
   assign analog_interface_bus_reset_out = ~rel_q;
   assign master_to_control_wake_interrupt_out = wake_q;
   assign gpio_pullup_enable_out         = 1'b0;
   assign hard_fault_out                 = fault_q;
   assign boot_busy_out                  = (state_q != ST_RUN);
   assign boot_done_out                  = (state_q == ST_RUN);
   assign boot_mode_out                  = mode_q;
   assign boot_sel_out.code              = code_q;
   assign boot_sel_out.serial_slave      = (mode_q == BM_SERIAL_SLAVE);
   assign boot_sel_out.ssp_master        = (mode_q == BM_SSP_MASTER);
   assign boot_sel_out.i2c_master        = (mode_q == BM_I2C_MASTER);

endmodule : dcbs_boot_sequencer

// >>> dcbs_pkg.sv
// dcbs_pkg: constants, types and boot-mode codes for the boot sequencer
// assumes a single 40 MHz clock domain and a synchronous active-high reset
package dcbs_pkg;

   localparam int          BOOT_SEL_WIDTH   = 4;
   localparam int          INIT_CYCLES_DEF  = 16;
   localparam int          MODE_WIDTH       = 4;

   // four-bit boot-select codes
   localparam logic [3:0]  SEL_PARALLEL     = 4'h0;
   localparam logic [3:0]  SEL_RAM          = 4'h1;
   localparam logic [3:0]  SEL_SERIAL_SLAVE = 4'h2;
   localparam logic [3:0]  SEL_CAN          = 4'h3;
   localparam logic [3:0]  SEL_ETHERNET     = 4'h4;
   localparam logic [3:0]  SEL_OTP          = 4'h6;
   localparam logic [3:0]  SEL_FLASH        = 4'h7;
   localparam logic [3:0]  SEL_SSP_MASTER   = 4'h9;
   localparam logic [3:0]  SEL_I2C_MASTER   = 4'hA;
   localparam int          TOP_SEL_BIT      = 3;

   // reset-cause bit positions
   localparam int          CAUSE_POWER_UP   = 0;
   localparam int          CAUSE_EXTERNAL   = 1;
   localparam int          CAUSE_DEBUGGER   = 2;
   localparam int          CAUSE_SOFTWARE   = 3;
   localparam int          CAUSE_WATCHDOG   = 4;
   localparam int          CAUSE_NMI_WDOG   = 5;
   localparam int          CAUSE_WIDTH      = 6;

   typedef enum logic [3:0] {
      BM_PARALLEL     = 4'h0,
      BM_RAM          = 4'h1,
      BM_SERIAL_SLAVE = 4'h2,
      BM_CAN          = 4'h3,
      BM_ETHERNET     = 4'h4,
      BM_OTP          = 4'h5,
      BM_FLASH        = 4'h6,
      BM_SSP_MASTER   = 4'h7,
      BM_I2C_MASTER   = 4'h8
   } dcbs_mode_type;

   // gray code along reset -> device init -> master init -> release -> ...
   typedef enum logic [2:0] {
      ST_RESET    = 3'b000,
      ST_DEV_INIT = 3'b001,
      ST_MST_INIT = 3'b011,
      ST_RELEASE  = 3'b010,
      ST_SAMPLE   = 3'b110,
      ST_DISPATCH = 3'b111,
      ST_RUN      = 3'b101,
      ST_FAULT    = 3'b100
   } dcbs_state_type;

   typedef struct packed {
      logic       ssp_master;
      logic       i2c_master;
      logic       serial_slave;
      logic [3:0] code;
   } dcbs_sel_type;

endpackage : dcbs_pkg

// >>> dcbs_strap_model.sv
// dcbs_strap_model: board straps and control-side boot behaviour
// assumes the bench names the wanted code; control reset from the block
`timescale 1ns/1ps
module dcbs_strap_model (
   // clock and controls
   input  wire logic       mclk_in,
   input  wire logic       drive_in,
   input  wire logic [3:0] code_in,
   input  wire logic       control_reset_in,
   // pins and control status
   output logic [3:0]      pins_out,
   output logic            control_idle_out
);
   logic [3:0] last_q;
   logic [2:0] boot_q;
   always_ff @(posedge mclk_in) begin
      if (drive_in) last_q <= code_in;
      if (control_reset_in) boot_q <= 3'h0;
      else if (boot_q != 3'h7) boot_q <= boot_q + 3'h1;
   end
   // undriven pins have no pull, so show a changed level
   assign pins_out = drive_in ? code_in : ~last_q;
   assign control_idle_out = (boot_q == 3'h7);
endmodule : dcbs_strap_model

// >>> dual_core_boot_sequencer_test.sv
// dual_core_boot_sequencer_test: self-checking bench
// assumes dcbs_strap_model on the pins, inputs set at falling edge
`timescale 1ns/1ps
module dual_core_boot_sequencer_test;
   import dcbs_pkg::*;
   localparam int N = 2;
   logic mclk_in = 0, srst_in = 1, later_revision_in = 1;
   logic test_version_in = 0, debug_probe_in = 0, remap_enable_in = 0;
   logic boot_select_bit1_in, boot_select_bit2_in;
   logic boot_select_bit3_in, boot_select_bit4_in;
   logic control_idle_in, wake_request_in = 0, flash_valid_in = 1;
   logic [CAUSE_WIDTH-1:0] reset_cause_in = '0;
   logic [3:0] remap_select_in = '0, code = '0;
   logic control_reset_out, analog_reset_out, boot_busy_out;
   logic analog_interface_bus_reset_out, boot_done_out, hard_fault_out;
   logic master_to_control_wake_interrupt_out, gpio_pullup_enable_out;
   dcbs_mode_type boot_mode_out;
   dcbs_sel_type  boot_sel_out;
   int num_errors = 0, num_checks = 0;
   always #12.5 mclk_in = ~mclk_in;
   dcbs_boot_sequencer #(.INIT_CYCLES(N)) u_dcbs_boot_sequencer (.*);
   dcbs_strap_model u_dcbs_strap_model (.mclk_in(mclk_in), .drive_in(1'b1),
      .code_in(code), .control_reset_in(control_reset_out),
      .pins_out({boot_select_bit4_in, boot_select_bit3_in,
                 boot_select_bit2_in, boot_select_bit1_in}),
      .control_idle_out(control_idle_in));
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [3:0] exp_mode(logic [3:0] c);
      logic [3:0] k;
      k = later_revision_in ? c : {1'b0, c[2:0]};
      case (k)
         4'h0: return BM_PARALLEL;
         4'h1: return BM_RAM;
         4'h2: return BM_SERIAL_SLAVE;
         4'h3: return BM_CAN;
         4'h4: return BM_ETHERNET;
         4'h6: return test_version_in ? BM_OTP : BM_FLASH;
         4'h9: return BM_SSP_MASTER;
         4'hA: return BM_I2C_MASTER;
         default: return BM_FLASH;
      endcase
   endfunction : exp_mode
   task automatic wait_hi(ref logic s);
      int i;
      for (i = 0; i < 60 && s !== 1'b1; i++) @(negedge mclk_in);
      if (i == 60) begin
         num_errors++;
         wrap_up();
      end
   endtask : wait_hi
   task automatic boot(logic [3:0] c, logic [3:0] e);
      code = c;
      srst_in = 1;
      repeat (2) @(negedge mclk_in);
      srst_in = 0;
      wait_hi(boot_done_out);
      chk("mode", exp_mode(e), boot_mode_out);
      chk("code", later_revision_in ? e : {1'b0, e[2:0]},
          boot_sel_out.code);
   endtask : boot
   task automatic t_codes();
      for (int c = 0; c < 16; c++) boot(c[3:0], c[3:0]);
      test_version_in = 1;
      boot(4'h6, 4'h6);
      test_version_in = 0;
   endtask : t_codes
   task automatic t_initial();
      later_revision_in = 0;
      remap_enable_in = 1;
      remap_select_in = 4'h4;
      boot(4'hF, 4'hF);
      boot(4'hB, 4'hB);
      later_revision_in = 1;
      remap_select_in = 4'h3;
      boot(4'h7, 4'h3);
      remap_enable_in = 0;
   endtask : t_initial
   task automatic t_hold_wake();
      code = 4'h5;
      wait_hi(control_idle_in);
      chk("held code", 4'h3, boot_sel_out.code);
      wake_request_in = 1;
      @(negedge mclk_in);
      chk("wake", 4'h1, master_to_control_wake_interrupt_out);
      wake_request_in = 0;
      @(negedge mclk_in);
      chk("wake off", 4'h0, master_to_control_wake_interrupt_out);
   endtask : t_hold_wake
   task automatic t_causes();
      for (int b = 0; b < CAUSE_WIDTH; b++) begin
         reset_cause_in = 6'h01 << b;
         @(negedge mclk_in);
         reset_cause_in = '0;
         chk("ctl reset", 4'h1, control_reset_out);
         wait_hi(boot_done_out);
         chk("reboot", 4'h1, boot_done_out);
      end
   endtask : t_causes
   task automatic t_fault();
      flash_valid_in = 0;
      code = 4'h7;
      srst_in = 1;
      @(negedge mclk_in);
      srst_in = 0;
      wait_hi(hard_fault_out);
      @(negedge mclk_in);
      chk("fault reset", 4'h1, control_reset_out);
      wait_hi(hard_fault_out);
      chk("fault loop", 4'h0, boot_done_out);
      debug_probe_in = 1;
      @(negedge mclk_in);
      wait_hi(hard_fault_out);
      repeat (3) @(negedge mclk_in);
      chk("parked", 4'h1, hard_fault_out);
      chk("parked done", 4'h0, boot_done_out);
      debug_probe_in = 0;
      flash_valid_in = 1;
      wait_hi(boot_done_out);
      chk("flash", BM_FLASH, boot_mode_out);
   endtask : t_fault
   initial begin
      repeat (8) @(negedge mclk_in);
      t_codes();
      t_initial();
      t_hold_wake();
      t_causes();
      t_fault();
      wrap_up();
   end
endmodule : dual_core_boot_sequencer_test
